// ---- cmtx_defines.svh ----
// constants of the carrier modulator transmitter: offsets, fields, reset values
// How it works
// - with generator and pin output both enabled, the pin follows the transmitter output.
// - with the generator off and the pin output enabled, the pin shows the software latch bit.
// - with the pin output disabled, the pin is released whatever the generator does.
// - counting and end-of-cycle events continue while the pin is released, as a modulo timer.
// - the input clock is divided by one, two, four or eight before the counters see it.
// - an interrupt request is raised at the end of each modulation cycle when enabled.
// - extended space forces modulator cycles to be spaces in time, baseband and shift modes.
// - time, baseband, frequency-shift and direct software pin control are the four modes.
// - the carrier counter counts up, compares before each step, reloads to one on a match
// - in frequency-shift mode the carrier swaps count sets at each modulator cycle end.
`ifndef CMTX_DEFINES_SVH
`define CMTX_DEFINES_SVH
`define CMTX_ADDR_W 3
`define CMTX_DATA_W 8
// register offsets
`define CMTX_OFS_PRI_HIGH 3'h0
`define CMTX_OFS_PRI_LOW 3'h1
`define CMTX_OFS_SEC_HIGH 3'h2
`define CMTX_OFS_SEC_LOW 3'h3
`define CMTX_OFS_OUT_CTRL 3'h4
`define CMTX_OFS_MOD_CTRL 3'h5
`define CMTX_OFS_MARK 3'h6
`define CMTX_OFS_SPACE 3'h7
// output control fields
`define CMTX_OC_PIN_EN 0
`define CMTX_OC_LATCH 1
// modulator status and control fields
`define CMTX_MSC_GEN_EN 0
`define CMTX_MSC_IRQ_EN 1
`define CMTX_MSC_BASE 2
`define CMTX_MSC_FSK 3
`define CMTX_MSC_EXSP 4
`define CMTX_MSC_DIV_LO 5
`define CMTX_MSC_DIV_HI 6
`define CMTX_MSC_EOC 7
// reset values
`define CMTX_RST_COUNT 8'h01
`define CMTX_RST_BYTE 8'h00
`define CMTX_CNT_ONE 8'h01
// prescaler masks for divide by 1, 2, 4, 8
`define CMTX_DIV_MASK_1 3'h0
`define CMTX_DIV_MASK_2 3'h1
`define CMTX_DIV_MASK_4 3'h3
`define CMTX_DIV_MASK_8 3'h7
// modulator ticks once per eight carrier clocks
`define CMTX_MOD_DIV_MAX 3'h7
`endif

// ---- cmtx_pkg.sv ----
// types of the carrier modulator transmitter
`default_nettype none
package cmtx_pkg;
   // gray coded modulator phase: idle -> mark -> space -> mark
   typedef enum logic [1:0] {
      CMTX_MOD_IDLE = 2'b00,
      CMTX_MOD_MARK = 2'b01,
      CMTX_MOD_SPACE = 2'b11
   } cmtx_mod_state_t;
endpackage
`default_nettype wire

// ---- cmtx_carrier_gen.sv ----
// carrier generator: high/low time up counter
`include "cmtx_defines.svh"
`default_nettype none
module cmtx_carrier_gen (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic tick,
   input wire logic [7:0] high_cnt,
   input wire logic [7:0] low_cnt,
   output logic carrier
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic level_q;
   logic level_d;
   wire [7:0] cmp_val;
   wire hit;

   // compare against the count of the phase in progress
   assign cmp_val = level_q ? high_cnt : low_cnt;
   assign hit = (cnt_q == cmp_val);
   // a zero count matches only once the counter wraps to zero, so that phase lasts 256 ticks
   assign cnt_d = !run ? `CMTX_CNT_ONE :
                  !tick ? cnt_q :
                  hit ? `CMTX_CNT_ONE : cnt_q + `CMTX_CNT_ONE;
   assign level_d = !run ? 1'b1 : (tick && hit) ? ~level_q : level_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= `CMTX_RST_COUNT;
         level_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         level_q <= level_d;
      end
   end

   assign carrier = level_q;
endmodule
`default_nettype wire

// ---- cmtx_top.sv ----
// carrier modulator transmitter: registers, prescaler, modulator, pin output
`include "cmtx_defines.svh"
`default_nettype none
module cmtx_top
   import cmtx_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [`CMTX_ADDR_W-1:0] addr,
   input wire logic [`CMTX_DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [`CMTX_DATA_W-1:0] rdata,
   output logic irq,
   output logic infrared_out_pin_o,
   output logic infrared_out_pin_oe
);
   // software registers
   logic [7:0] pri_high_q;
   logic [7:0] pri_low_q;
   logic [7:0] sec_high_q;
   logic [7:0] sec_low_q;
   logic [7:0] mark_q;
   logic [7:0] space_q;
   logic output_pin_enable_q;
   logic pin_software_latch_q;
   logic generator_enable_q;
   logic irq_en_q;
   logic baseband_q;
   logic fsk_q;
   logic extended_space_select_q;
   logic [1:0] clock_divide_select_q;
   logic eoc_flag_q;
   logic [7:0] rdata_q;
   logic irq_q;
   logic pin_q;
   logic pin_oe_q;
   // engine state
   logic [2:0] pre_q;
   logic [2:0] mdiv_q;
   logic [7:0] mcnt_q;
   logic use_sec_q;
   cmtx_mod_state_t mst_q;
   cmtx_mod_state_t mst_d;
   logic [7:0] mcnt_d;

   // address decode
   wire wr_ph = wr && (addr == `CMTX_OFS_PRI_HIGH);
   wire wr_pl = wr && (addr == `CMTX_OFS_PRI_LOW);
   wire wr_sh = wr && (addr == `CMTX_OFS_SEC_HIGH);
   wire wr_sl = wr && (addr == `CMTX_OFS_SEC_LOW);
   wire wr_oc = wr && (addr == `CMTX_OFS_OUT_CTRL);
   wire wr_msc = wr && (addr == `CMTX_OFS_MOD_CTRL);
   wire wr_mk = wr && (addr == `CMTX_OFS_MARK);
   wire wr_sp = wr && (addr == `CMTX_OFS_SPACE);

   // read mux; every offset of the 3-bit space is mapped
   wire [7:0] oc_rd = {6'h00, pin_software_latch_q, output_pin_enable_q};
   wire [7:0] msc_rd = {eoc_flag_q, clock_divide_select_q, extended_space_select_q,
                        fsk_q, baseband_q, irq_en_q, generator_enable_q};
   wire [7:0] rd_mux = (addr == `CMTX_OFS_PRI_HIGH) ? pri_high_q :
                       (addr == `CMTX_OFS_PRI_LOW) ? pri_low_q :
                       (addr == `CMTX_OFS_SEC_HIGH) ? sec_high_q :
                       (addr == `CMTX_OFS_SEC_LOW) ? sec_low_q :
                       (addr == `CMTX_OFS_OUT_CTRL) ? oc_rd :
                       (addr == `CMTX_OFS_MOD_CTRL) ? msc_rd :
                       (addr == `CMTX_OFS_MARK) ? mark_q : space_q;

   // prescaler: tick when the selected low bits are all ones
   wire [2:0] div_mask = (clock_divide_select_q == 2'h0) ? `CMTX_DIV_MASK_1 :
                         (clock_divide_select_q == 2'h1) ? `CMTX_DIV_MASK_2 :
                         (clock_divide_select_q == 2'h2) ? `CMTX_DIV_MASK_4 :
                         `CMTX_DIV_MASK_8;
   wire pre_tick = generator_enable_q && ((pre_q & div_mask) == div_mask);
   wire mod_tick = pre_tick && (mdiv_q == `CMTX_MOD_DIV_MAX);

   // carrier count set; shift mode may swap to the secondary pair
   wire sel_sec = fsk_q && !baseband_q && use_sec_q;
   wire [7:0] hi_sel = sel_sec ? sec_high_q : pri_high_q;
   wire [7:0] lo_sel = sel_sec ? sec_low_q : pri_low_q;
   wire carrier_raw;
   wire carrier = baseband_q ? 1'b1 : carrier_raw;

   cmtx_carrier_gen u_carrier (
      .mclk(mclk),
      .rst_n(rst_n),
      .run(generator_enable_q && !baseband_q),
      .tick(pre_tick),
      .high_cnt(hi_sel),
      .low_cnt(lo_sel),
      .carrier(carrier_raw)
   );

   // modulator: mark phase opens the gate, space closes it, space end closes the cycle
   wire mark_done = (mcnt_q >= mark_q);
   wire space_done = (mcnt_q >= space_q);
   wire eoc = mod_tick && (mst_q == CMTX_MOD_SPACE) && space_done;

   always_comb begin
      mst_d = mst_q;
      mcnt_d = mcnt_q;
      if (!generator_enable_q) begin
         mst_d = CMTX_MOD_IDLE;
         mcnt_d = `CMTX_RST_BYTE;
      end else begin
         unique case (mst_q)
            CMTX_MOD_IDLE: begin
               mst_d = CMTX_MOD_MARK;
               mcnt_d = `CMTX_RST_BYTE;
            end
            CMTX_MOD_MARK: begin
               if (mod_tick) begin
                  mcnt_d = mark_done ? `CMTX_RST_BYTE : mcnt_q + `CMTX_CNT_ONE;
                  mst_d = mark_done ? CMTX_MOD_SPACE : CMTX_MOD_MARK;
               end
            end
            CMTX_MOD_SPACE: begin
               if (mod_tick) begin
                  mcnt_d = space_done ? `CMTX_RST_BYTE : mcnt_q + `CMTX_CNT_ONE;
                  mst_d = space_done ? CMTX_MOD_MARK : CMTX_MOD_SPACE;
               end
            end
            default: begin
               mst_d = CMTX_MOD_IDLE;
               mcnt_d = `CMTX_RST_BYTE;
            end
         endcase
      end
   end

   // gate is open only in the mark phase and never under extended space
   wire gate = (mst_q == CMTX_MOD_MARK) && !extended_space_select_q;
   wire tx_out = gate && carrier;
   wire pin_d = generator_enable_q ? tx_out : pin_software_latch_q;
   // a flag raised in the cycle software clears it survives
   wire eoc_clr = wr_msc && wdata[`CMTX_MSC_EOC];
   wire eoc_d = eoc | (eoc_flag_q & ~eoc_clr);

   // engine registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 3'h0;
         mdiv_q <= 3'h0;
         mcnt_q <= `CMTX_RST_BYTE;
         mst_q <= CMTX_MOD_IDLE;
         use_sec_q <= 1'b0;
      end else begin
         pre_q <= generator_enable_q ? pre_q + 3'h1 : 3'h0;
         mdiv_q <= !generator_enable_q ? 3'h0 : pre_tick ? mdiv_q + 3'h1 : mdiv_q;
         mcnt_q <= mcnt_d;
         mst_q <= mst_d;
         use_sec_q <= !generator_enable_q ? 1'b0 : eoc ? ~use_sec_q : use_sec_q;
      end
   end

   // carrier count registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pri_high_q <= `CMTX_RST_BYTE;
         pri_low_q <= `CMTX_RST_BYTE;
         sec_high_q <= `CMTX_RST_BYTE;
         sec_low_q <= `CMTX_RST_BYTE;
      end else begin
         if (wr_ph) pri_high_q <= wdata;
         if (wr_pl) pri_low_q <= wdata;
         if (wr_sh) sec_high_q <= wdata;
         if (wr_sl) sec_low_q <= wdata;
      end
   end

   // modulator times and control bits
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mark_q <= `CMTX_RST_BYTE;
         space_q <= `CMTX_RST_BYTE;
         output_pin_enable_q <= 1'b0;
         pin_software_latch_q <= 1'b0;
         generator_enable_q <= 1'b0;
         irq_en_q <= 1'b0;
         baseband_q <= 1'b0;
         fsk_q <= 1'b0;
         extended_space_select_q <= 1'b0;
         clock_divide_select_q <= 2'h0;
      end else begin
         if (wr_mk) mark_q <= wdata;
         if (wr_sp) space_q <= wdata;
         if (wr_oc) begin
            output_pin_enable_q <= wdata[`CMTX_OC_PIN_EN];
            pin_software_latch_q <= wdata[`CMTX_OC_LATCH];
         end
         if (wr_msc) begin
            generator_enable_q <= wdata[`CMTX_MSC_GEN_EN];
            irq_en_q <= wdata[`CMTX_MSC_IRQ_EN];
            baseband_q <= wdata[`CMTX_MSC_BASE];
            fsk_q <= wdata[`CMTX_MSC_FSK];
            extended_space_select_q <= wdata[`CMTX_MSC_EXSP];
            clock_divide_select_q <= wdata[`CMTX_MSC_DIV_HI:`CMTX_MSC_DIV_LO];
         end
      end
   end

   // outputs straight from flops; pin value kept even while released
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         eoc_flag_q <= 1'b0;
         rdata_q <= `CMTX_RST_BYTE;
         irq_q <= 1'b0;
         pin_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         eoc_flag_q <= eoc_d;
         rdata_q <= rd ? rd_mux : `CMTX_RST_BYTE;
         irq_q <= eoc_d && irq_en_q;
         pin_q <= pin_d;
         pin_oe_q <= output_pin_enable_q;
      end
   end

   assign rdata = rdata_q;
   assign irq = irq_q;
   assign infrared_out_pin_o = pin_q;
   assign infrared_out_pin_oe = pin_oe_q;
endmodule
`default_nettype wire

// ---- cmtx_checker.sv ----
// port checker of the transmitter, bound to its top
`default_nettype none
module cmtx_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic irq,
   input wire logic infrared_out_pin_o,
   input wire logic infrared_out_pin_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [7:0] sh_q [8];
   logic [7:0] exp_q;
   wire logic w5 = wr && addr == 3'h5;
   wire logic gen = sh_q[5][0];
   // mirror of written bytes; the end flag is not mirrored
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= '{default: 8'h00};
         exp_q <= 8'h00;
      end else begin
         if (wr) sh_q[addr] <= wdata;
         if (rd) exp_q <= sh_q[addr];
      end
   end
   // pin enable write, then a quiet cycle
   sequence s_pen_wr;
      wr && addr == 3'h4 ##1 !(wr && addr == 3'h4);
   endsequence
   a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside a read");
   a_count_rb: assert property (rd && addr[2:1] != 2'b10 |=> rdata == exp_q)
      else $error("count register readback");
   a_mode_rb: assert property (rd && addr == 3'h5 |=> rdata[6:0] == exp_q[6:0])
      else $error("mode register readback");
   a_oe_follow: assert property (s_pen_wr |=> infrared_out_pin_oe == $past(wdata[0], 2))
      else $error("pin enable not applied");
   a_latch_pin: assert property (!gen |=> infrared_out_pin_o == $past(sh_q[4][1]))
      else $error("pin not following latch");
   a_space_dark: assert property (gen && sh_q[5][4] |=> !infrared_out_pin_o)
      else $error("pin lit in extended space");
   a_irq_mask: assert property (w5 && !wdata[1] |-> ##2 !irq)
      else $error("request while masked");
   a_irq_idle: assert property (!gen && !irq && !w5 && !$past(w5) |=> !irq)
      else $error("request with generator off");
endmodule
bind cmtx_top cmtx_checker cmtx_checker_inst (.mclk, .rst_n, .addr, .wdata, .wr, .rd,
   .rdata, .irq, .infrared_out_pin_o, .infrared_out_pin_oe);
`default_nettype wire

// ---- cmtx_emitter.sv ----
// emitter model on the output pin
`default_nettype none
module cmtx_emitter (
   input wire logic drive,
   input wire logic enable,
   output logic lit
);
   // a released line sinks to its pull-down, never keeps the last value
   assign lit = enable ? drive : 1'b0;
endmodule
`default_nettype wire

// ---- cmtx_bench.sv ----
// self-checking bench of the transmitter
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module cmtx_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, rdata, rb;
   logic irq, pin_o, pin_oe, lit;
   integer seed = 32'hed60572d;
   int failures = 0, num_checks = 0, h, l, c, n;
   int regs [8];
   always #5 mclk = ~mclk;
   cmtx_top cmtx_top_inst (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .irq,
      .infrared_out_pin_o(pin_o), .infrared_out_pin_oe(pin_oe));
   cmtx_emitter cmtx_emitter_inst (.drive(pin_o), .enable(pin_oe), .lit);
   // strobes rise just after an edge and last one cycle
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      regs[a] = d;
   endtask
   task automatic rreg(input logic [2:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      rb = rdata;
   endtask
   // cycles the pin keeps one level, counted from the mid-cycle sample in hand
   task automatic run_len(input logic lvl, output int k);
      k = 0;
      while (lit === lvl && k < 20000) begin
         @(negedge mclk);
         k++;
      end
   endtask
   // start-up and set swaps leave odd runs, so drop the run in progress first
   task automatic measure(output int hi, output int lo);
      repeat (4) @(negedge mclk);
      run_len(lit, hi);
      run_len(1'b0, hi);
      run_len(1'b1, hi);
      run_len(1'b0, lo);
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // hang guard, far beyond the expected run
   initial begin
      #200us;
      failures++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      // random non-zero bytes in the plain registers, each read back
      for (int a = 0; a < 8; a++) begin
         if (a[2:1] != 2'b10) begin
            wreg(a[2:0], 8'(1 + {$random(seed)} % 255));
            rreg(a[2:0]);
            `CHK("count reg", regs[a][7:0], rb)
         end
      end
      // pin enable and latch in all four combinations
      for (int v = 0; v < 4; v++) begin
         wreg(3'h4, v[7:0]);
         repeat (2) @(negedge mclk);
         `CHK("pin level", v == 3, lit)
         `CHK("pin enable", v[0], pin_oe)
      end
      // carrier times under each prescaler, long mark
      wreg(3'h6, 8'hff);
      for (int dv = 0; dv < 4; dv++) begin
         h = 1 + {$random(seed)} % 12;
         l = 1 + {$random(seed)} % 12;
         wreg(3'h0, h[7:0]);
         wreg(3'h1, l[7:0]);
         wreg(3'h5, {1'b0, dv[1:0], 5'h01});
         measure(c, n);
         `CHK("carrier high", h << dv, c)
         `CHK("carrier low", l << dv, n)
         wreg(3'h5, 8'h00);
      end
      // shift keying: primary counts in the first mark, secondary after its end
      h = 1 + {$random(seed)} % 12;
      l = 1 + {$random(seed)} % 12;
      wreg(3'h2, h[7:0]);
      wreg(3'h3, l[7:0]);
      wreg(3'h7, 8'h00);
      wreg(3'h5, 8'h0b);
      measure(c, n);
      `CHK("primary high", regs[0], c)
      `CHK("primary low", regs[1], n)
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      `CHK("cycle end irq", 1'b1, irq)
      measure(c, n);
      `CHK("secondary high", h, c)
      `CHK("secondary low", l, n)
      // stop first, so no cycle end can race the flag clear
      wreg(3'h5, 8'h00);
      wreg(3'h5, 8'h80);
      // baseband timer with the pin released
      h = 1 + {$random(seed)} % 8;
      l = 1 + {$random(seed)} % 8;
      wreg(3'h6, h[7:0]);
      wreg(3'h7, l[7:0]);
      wreg(3'h4, 8'h00);
      wreg(3'h5, 8'h07);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(negedge mclk);
         n++;
      end
      `CHK("timer irq", 1'b1, irq)
      `CHK("pin released", 1'b0, pin_oe)
      rreg(3'h5);
      `CHK("end flag", 1'b1, rb[7])
      wreg(3'h5, 8'h87);
      repeat (3) @(negedge mclk);
      `CHK("irq cleared", 1'b0, irq)
      wreg(3'h5, 8'h05);
      repeat ((h + l + 2) * 16) @(negedge mclk);
      `CHK("irq masked", 1'b0, irq)
      rreg(3'h5);
      `CHK("masked flag", 1'b1, rb[7])
      // baseband mark and space seen on the pin
      wreg(3'h4, 8'h01);
      measure(c, n);
      `CHK("mark time", (h + 1) * 8, c)
      `CHK("space time", (l + 1) * 8, n)
      // extended space keeps the pin dark
      wreg(3'h5, 8'h15);
      repeat (3) @(negedge mclk);
      n = 0;
      repeat (300) begin
         @(negedge mclk);
         n += (lit !== 1'b0);
      end
      `CHK("extended space", 0, n)
      // generator off: counters idle, latch owns the pin
      wreg(3'h5, 8'h00);
      wreg(3'h5, 8'h80);
      wreg(3'h5, 8'h82);
      wreg(3'h4, 8'h03);
      repeat (400) @(negedge mclk);
      `CHK("idle irq", 1'b0, irq)
      `CHK("latch pin", 1'b1, lit)
      conclude();
   end
endmodule
`default_nettype wire
